// ---- scc_map.svh ----
// Constants for the two-wire host controller of the touch-sensor client
// Overview of operation
// - Host may stretch clock; client never does
// - Start: data falls while clock high
// - First byte: 7-bit address plus direction bit
// - Bytes are eight bits, MSB first
// - Host acks read bytes except the last
// - Stop: data rises while clock high
// - Blocks carry no count byte, 1 to 255 bytes long
// - Write byte: address, register, data, stop
// - Read byte: register, restart, read, nack
// - Bus clock between 10kHz and 400kHz
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SCC_CLK_PERIOD_NS 40
`define SCC_T_LOW_NS 1300
`define SCC_T_PWRUP_MS 15
// Each SCL phase is two quarters; low phase must reach its least time
`define SCC_QTR_CYC ((`SCC_T_LOW_NS + 2 * `SCC_CLK_PERIOD_NS - 1) / (2 * `SCC_CLK_PERIOD_NS))
`define SCC_PWRUP_CYC ((`SCC_T_PWRUP_MS * 1000000 + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)

// ****************************************************************
// Client addresses per strap
// ****************************************************************
`define SCC_ADDR_82K 7'h2c
`define SCC_ADDR_100K 7'h2b
`define SCC_ADDR_120K 7'h2a
`define SCC_ADDR_150K 7'h29
`define SCC_ADDR_VDD 7'h28

// ****************************************************************
// Field layout
// ****************************************************************
`define SCC_DIR_WRITE 1'b0
`define SCC_DIR_READ 1'b1
`define SCC_BYTE_BITS 8
`define SCC_PTR_WRAP 8'hff

`endif

// ---- scc_pkg.sv ----
// Types shared by the two-wire host controller files
package scc_pkg;

  // Strap pull-down seen on the protocol select pin
  typedef enum logic [2:0] {
    SCC_STRAP_GND,
    SCC_STRAP_56K,
    SCC_STRAP_68K,
    SCC_STRAP_82K,
    SCC_STRAP_100K,
    SCC_STRAP_120K,
    SCC_STRAP_150K,
    SCC_STRAP_VDD
  } scc_strap_t;

  typedef enum logic [1:0] {
    SCC_PROTO_SPI4,
    SCC_PROTO_SPI3,
    SCC_PROTO_LINK,
    SCC_PROTO_SMBUS
  } scc_proto_t;

  typedef enum logic [2:0] {
    SCC_OP_WRITE_BYTE,
    SCC_OP_READ_BYTE,
    SCC_OP_SEND_BYTE,
    SCC_OP_RECV_BYTE,
    SCC_OP_BLOCK_WRITE,
    SCC_OP_BLOCK_READ
  } scc_op_t;

  typedef struct packed {
    scc_op_t op;
    logic [7:0] reg_addr;
    logic [7:0] count;
  } scc_cmd_t;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } scc_pins_t;

endpackage : scc_pkg

// ---- scc_strap_decode.sv ----
// Strap decode: protocol choice and client address
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_strap_decode (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Strap
  input wire scc_pkg::scc_strap_t strap_in,
  // Decoded
  output scc_pkg::scc_proto_t proto_out,
  output logic [6:0] addr_out
);
  import scc_pkg::*;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      proto_out <= SCC_PROTO_SMBUS;
      addr_out <= `SCC_ADDR_VDD;
    end else begin
      case (strap_in)
        SCC_STRAP_GND: proto_out <= SCC_PROTO_SPI4;
        SCC_STRAP_56K: proto_out <= SCC_PROTO_SPI3;
        SCC_STRAP_68K: proto_out <= SCC_PROTO_LINK;
        default: proto_out <= SCC_PROTO_SMBUS;
      endcase
      case (strap_in)
        SCC_STRAP_82K: addr_out <= `SCC_ADDR_82K;
        SCC_STRAP_100K: addr_out <= `SCC_ADDR_100K;
        SCC_STRAP_120K: addr_out <= `SCC_ADDR_120K;
        SCC_STRAP_150K: addr_out <= `SCC_ADDR_150K;
        default: addr_out <= `SCC_ADDR_VDD;
      endcase
    end
  end

endmodule : scc_strap_decode

// ---- scc_host.sv ----
// Two-wire host controller driving the touch-sensor client
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_host #(
  parameter int PWRUP_CYC = `SCC_PWRUP_CYC,
  parameter int QTR_CYC = `SCC_QTR_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Board configuration
  input wire scc_pkg::scc_strap_t strap_in,
  input wire logic deep_sleep_flag_in,
  output scc_pkg::scc_proto_t proto_out,
  // Commands
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire scc_pkg::scc_cmd_t cmd_in,
  // Write data stream
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [7:0] wr_data_in,
  // Read data and status
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic done_out,
  output logic nack_out,
  output logic busy_out,
  output logic [7:0] ptr_out,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output scc_pkg::scc_pins_t pins_out
);
  import scc_pkg::*;

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_START,
    ST_BYTE,
    ST_ACK,
    ST_LOAD,
    ST_STOP
  } scc_state_t;

  typedef enum logic [2:0] {
    BY_ADDR_W,
    BY_REG,
    BY_DATA_W,
    BY_ADDR_R,
    BY_DATA_R
  } scc_byte_t;

  localparam int PW = $clog2(PWRUP_CYC + 1);
  localparam int QW = $clog2(QTR_CYC + 1);

  scc_state_t state_q;
  scc_byte_t kind_q;
  scc_op_t op_q;
  logic [PW-1:0] pwr_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0] qtr_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] reg_q;
  logic [7:0] left_q;
  logic [7:0] ptr_q;
  logic ack_ok_q;
  logic scl_hi_q;
  logic sda_hi_q;
  logic [6:0] caddr;
  logic tick;
  logic last_qtr;
  logic is_read_op;
  logic ptr_only;

  scc_strap_decode u_strap (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .strap_in(strap_in),
    .proto_out(proto_out),
    .addr_out(caddr)
  );

  // ****************************************************************
  // Command acceptance
  // ****************************************************************
  assign is_read_op = (cmd_in.op == SCC_OP_READ_BYTE) || (cmd_in.op == SCC_OP_BLOCK_READ);
  assign ptr_only = (cmd_in.op == SCC_OP_SEND_BYTE) || (cmd_in.op == SCC_OP_RECV_BYTE);
  // Pointer-only transfers are held back while the client sleeps deeply
  assign cmd_ready_out = (state_q == ST_IDLE) && (proto_out == SCC_PROTO_SMBUS)
                         && !(deep_sleep_flag_in && ptr_only);
  assign wr_ready_out = (state_q == ST_LOAD);
  assign busy_out = (state_q != ST_IDLE);
  assign ptr_out = ptr_q;

  // ****************************************************************
  // Quarter-bit timing
  // ****************************************************************
  // Quarter 2 is the first high quarter; it only ends once SCL is seen
  // high, so any party holding SCL low simply lengthens the bit
  assign last_qtr = (qcnt_q == QW'(QTR_CYC - 1));
  assign tick = last_qtr && !((qtr_q == 2'd2) && !scl_in);

  always_ff @(posedge clk_in) begin
    if (rst_in || state_q == ST_IDLE || state_q == ST_PWRUP || state_q == ST_LOAD) begin
      qcnt_q <= '0;
      qtr_q <= 2'd0;
    end else if (tick) begin
      qcnt_q <= '0;
      qtr_q <= qtr_q + 2'd1;
    end else if (!last_qtr) begin
      qcnt_q <= qcnt_q + QW'(1);
    end
  end

  // Client may be deaf for a while after power-up
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwr_q <= '0;
    end else if (pwr_q != PW'(PWRUP_CYC)) begin
      pwr_q <= pwr_q + PW'(1);
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_PWRUP;
      kind_q <= BY_ADDR_W;
      op_q <= SCC_OP_WRITE_BYTE;
      reg_q <= 8'h00;
      left_q <= 8'h00;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      ack_ok_q <= 1'b0;
    end else begin
      case (state_q)
        ST_PWRUP: begin
          if (pwr_q == PW'(PWRUP_CYC)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_valid_in && cmd_ready_out) begin
            op_q <= cmd_in.op;
            reg_q <= cmd_in.reg_addr;
            // Single transfers move one byte; blocks have no count byte
            left_q <= (cmd_in.op == SCC_OP_BLOCK_WRITE || cmd_in.op == SCC_OP_BLOCK_READ)
                      ? ((cmd_in.count == 8'h00) ? 8'h01 : cmd_in.count) : 8'h01;
            if (cmd_in.op == SCC_OP_RECV_BYTE) begin
              kind_q <= BY_ADDR_R;
              sh_q <= {caddr, `SCC_DIR_READ};
            end else begin
              kind_q <= BY_ADDR_W;
              sh_q <= {caddr, `SCC_DIR_WRITE};
            end
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick && qtr_q == 2'd3) begin
            bit_q <= 3'd0;
            state_q <= ST_BYTE;
          end
        end
        ST_BYTE: begin
          if (tick && qtr_q == 2'd3) begin
            // Sample at the end of the high phase; shift out the next bit MSB first
            sh_q <= {sh_q[6:0], sda_in};
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'(`SCC_BYTE_BITS - 1)) begin
              state_q <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (tick && qtr_q == 2'd3) begin
            ack_ok_q <= !sda_in;
            if (kind_q != BY_DATA_R && sda_in) begin
              state_q <= ST_STOP;
            end else begin
              case (kind_q)
                BY_ADDR_W: begin
                  kind_q <= BY_REG;
                  sh_q <= reg_q;
                  bit_q <= 3'd0;
                  state_q <= ST_BYTE;
                end
                BY_REG: begin
                  if (op_q == SCC_OP_SEND_BYTE) begin
                    state_q <= ST_STOP;
                  end else if (op_q == SCC_OP_READ_BYTE || op_q == SCC_OP_BLOCK_READ) begin
                    kind_q <= BY_ADDR_R;
                    sh_q <= {caddr, `SCC_DIR_READ};
                    state_q <= ST_START;
                  end else begin
                    kind_q <= BY_DATA_W;
                    state_q <= ST_LOAD;
                  end
                end
                BY_DATA_W: begin
                  left_q <= left_q - 8'h01;
                  state_q <= (left_q == 8'h01) ? ST_STOP : ST_LOAD;
                end
                BY_ADDR_R: begin
                  kind_q <= BY_DATA_R;
                  sh_q <= 8'hff;
                  bit_q <= 3'd0;
                  state_q <= ST_BYTE;
                end
                default: begin
                  left_q <= left_q - 8'h01;
                  if (left_q == 8'h01) begin
                    state_q <= ST_STOP;
                  end else begin
                    sh_q <= 8'hff;
                    bit_q <= 3'd0;
                    state_q <= ST_BYTE;
                  end
                end
              endcase
            end
          end
        end
        ST_LOAD: begin
          // SCL stays low while the source stalls; keep stalls well short
          // of the client's clock-low timeout
          if (wr_valid_in) begin
            sh_q <= wr_data_in;
            bit_q <= 3'd0;
            state_q <= ST_BYTE;
          end
        end
        ST_STOP: begin
          if (tick && qtr_q == 2'd3) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Lines are open-drain: a high level is released, never driven
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_hi_q <= 1'b1;
      sda_hi_q <= 1'b1;
    end else if (state_q == ST_IDLE || state_q == ST_PWRUP) begin
      scl_hi_q <= 1'b1;
      sda_hi_q <= 1'b1;
    end else if (state_q == ST_LOAD) begin
      scl_hi_q <= 1'b0;
    end else if (tick) begin
      case (state_q)
        ST_START: begin
          // A repeated start lets SCL finish a full low phase before rising
          scl_hi_q <= (qtr_q == 2'd0) ? scl_hi_q : (qtr_q != 2'd3);
          sda_hi_q <= !qtr_q[1];
        end
        ST_STOP: begin
          scl_hi_q <= (qtr_q != 2'd0);
          sda_hi_q <= qtr_q[1];
        end
        ST_BYTE: begin
          scl_hi_q <= (qtr_q == 2'd1) || (qtr_q == 2'd2);
          if (qtr_q == 2'd0) begin
            sda_hi_q <= (kind_q == BY_DATA_R) ? 1'b1 : sh_q[7];
          end
        end
        ST_ACK: begin
          scl_hi_q <= (qtr_q == 2'd1) || (qtr_q == 2'd2);
          if (qtr_q == 2'd0) begin
            // Host acks read bytes except the last one
            sda_hi_q <= (kind_q == BY_DATA_R) ? (left_q == 8'h01) : 1'b1;
          end
        end
        default: begin
          scl_hi_q <= scl_hi_q;
        end
      endcase
    end
  end

  // Byte and ack phases leave SCL low at their end, ready for the next
  always_comb begin
    pins_out.scl_out = 1'b0;
    pins_out.scl_oe = !scl_hi_q;
    pins_out.sda_out = 1'b0;
    pins_out.sda_oe = !sda_hi_q;
  end

  // ****************************************************************
  // Results and pointer mirror
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else begin
      rd_valid_out <= 1'b0;
      if (state_q == ST_BYTE && kind_q == BY_DATA_R && tick && qtr_q == 2'd3
          && bit_q == 3'(`SCC_BYTE_BITS - 1)) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= {sh_q[6:0], sda_in};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      nack_out <= 1'b0;
    end else begin
      done_out <= (state_q == ST_STOP) && tick && (qtr_q == 2'd3);
      if (state_q == ST_ACK && tick && qtr_q == 2'd3 && kind_q != BY_DATA_R) begin
        nack_out <= sda_in;
      end else if (state_q == ST_IDLE && cmd_valid_in && cmd_ready_out) begin
        nack_out <= 1'b0;
      end
    end
  end

  // Mirror of the client pointer; it survives between transfers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ptr_q <= 8'h00;
    end else if (state_q == ST_ACK && tick && qtr_q == 2'd3) begin
      if (kind_q == BY_REG && !sda_in) begin
        ptr_q <= reg_q;
      end else if (kind_q == BY_DATA_R
                   || (kind_q == BY_DATA_W && !sda_in)) begin
        ptr_q <= (ptr_q == `SCC_PTR_WRAP) ? 8'h00 : ptr_q + 8'h01;
      end
    end
  end

endmodule : scc_host

// ---- scc_host_sva.sv ----
// Port assertions for the two-wire host controller
`timescale 1ns/1ps
module scc_host_sva #(
  parameter int PWRUP_CYC = 20,
  parameter int QTR_CYC = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire scc_pkg::scc_strap_t strap_in,
  input wire logic deep_sleep_flag_in,
  input wire scc_pkg::scc_proto_t proto_out,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire scc_pkg::scc_cmd_t cmd_in,
  input wire logic wr_valid_in,
  input wire logic wr_ready_out,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_valid_out,
  input wire logic [7:0] rd_data_out,
  input wire logic done_out,
  input wire logic nack_out,
  input wire logic busy_out,
  input wire logic [7:0] ptr_out,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire scc_pkg::scc_pins_t pins_out
);
  import scc_pkg::*;
  logic take;
  assign take = cmd_valid_in & cmd_ready_out;
  int low_cnt;
  always_ff @(posedge clk_in) begin
    if (rst_in || !pins_out.scl_oe) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // Command port and bus shape
  // ****
  a_proto_gate: assert property (proto_out != SCC_PROTO_SMBUS |-> !cmd_ready_out)
    else $error("command ready outside two-wire mode");
  a_sleep_refuse: assert property (deep_sleep_flag_in &&
    (cmd_in.op inside {SCC_OP_SEND_BYTE, SCC_OP_RECV_BYTE}) |-> !cmd_ready_out)
    else $error("pointer-only command ready in deep sleep");
  a_ready_idle: assert property (!busy_out && proto_out == SCC_PROTO_SMBUS &&
    !deep_sleep_flag_in |-> cmd_ready_out) else $error("idle host refuses command");
  a_busy_take: assert property (take |=> busy_out)
    else $error("no busy after command taken");
  a_start_first: assert property (take |->
    ##[1:40] ($rose(pins_out.sda_oe) && !pins_out.scl_oe)) else $error("no start condition");
  a_nack_clear: assert property (take |=> !nack_out)
    else $error("nack flag kept after new command");
  a_wait_low: assert property (wr_ready_out && $past(wr_ready_out) |-> pins_out.scl_oe)
    else $error("clock released while waiting on data");
  a_idle_free: assert property (!busy_out |-> !pins_out.scl_oe && !pins_out.sda_oe)
    else $error("bus lines held while idle");
  a_low_time: assert property ($fell(pins_out.scl_oe) |-> low_cnt >= 2 * QTR_CYC)
    else $error("clock low phase too short");
  c_take: cover property (take);
  c_read: cover property (rd_valid_out);
  c_nack: cover property ($rose(nack_out));
endmodule : scc_host_sva

// ---- scc_client_model.sv ----
// Behavioural two-wire client: byte registers behind an address pointer
`timescale 1ns/1ps
module scc_client_model #(
  parameter int IGN_CYC = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bus; no chip-select input, as two-wire mode ignores it
  input wire logic [6:0] addr_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out
);
  logic [7:0] mem [256];
  logic [7:0] ptr, sh, tx;
  logic scl_q, sda_q, act, first, rd, regph, hack, txon;
  int cnt, ign;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Timeouts stay off, their default after reset SCL never driven
  always @(posedge clk_in) begin
    if (rst_in) begin
      ign = IGN_CYC;
      act = 1'b0;
      sda_oe_out = 1'b0;
      ptr = 8'h00;
      scl_q = 1'b1;
      sda_q = 1'b1;
    end else if (ign > 0) begin
      ign--;
    end else begin
      if (scl_in && scl_q && sda_q && !sda_in) begin
        act = 1'b1;
        first = 1'b1;
        rd = 1'b0;
        txon = 1'b0;
        cnt = 0;
        sda_oe_out = 1'b0;
      end else if (scl_in && scl_q && !sda_q && sda_in) begin
        act = 1'b0;
        sda_oe_out = 1'b0;
      end else if (act && scl_in && !scl_q) begin
        if (cnt < 8) sh = {sh[6:0], sda_in};
        else hack = !sda_in;
        cnt++;
      end else if (act && !scl_in && scl_q) begin
        if (cnt == 8 && first) begin
          act = (sh[7:1] == addr_in);
          rd = sh[0];
          regph = 1'b1;
          first = 1'b0;
          sda_oe_out = act;
        end else if (cnt == 8 && !rd) begin
          if (regph) ptr = sh;
          else begin
            mem[ptr] = sh;
            ptr++;
          end
          regph = 1'b0;
          sda_oe_out = 1'b1;
        end else if (cnt == 8) sda_oe_out = 1'b0;
        else if (cnt == 9) begin
          cnt = 0;
          sda_oe_out = 1'b0;
          if (rd && !hack) act = 1'b0;
          else if (rd) begin
            if (txon) ptr++;
            txon = 1'b1;
            tx = mem[ptr];
            sda_oe_out = !tx[7];
          end
        end else if (rd && txon) sda_oe_out = !tx[7 - cnt];
      end
      scl_q = scl_in;
      sda_q = sda_in;
    end
  end
endmodule : scc_client_model

// ---- scc_host_test.sv ----
// Self-checking bench for the two-wire host controller
`timescale 1ns/1ps
module scc_host_test;
  import scc_pkg::*;
  localparam int PWR = 20;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  scc_strap_t strap_in = SCC_STRAP_VDD;
  logic deep_sleep_flag_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  scc_cmd_t cmd_in = '0;
  logic wr_valid_in = 1'b0;
  logic [7:0] wr_data_in = 8'h00;
  logic [6:0] mdl_addr = 7'h28;
  scc_proto_t proto_out;
  scc_pins_t pins_out;
  logic cmd_ready_out, wr_ready_out, rd_valid_out, done_out, nack_out, busy_out, mdl_oe;
  logic [7:0] rd_data_out, ptr_out, ra, d;
  logic [7:0] seed = 8'h16;
  logic [7:0] shadow [256];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int num_errors = 0;
  int n_checks = 0;
  // Lines float high through the pull-ups when nobody pulls them
  wire logic scl = !pins_out.scl_oe;
  wire logic sda = !(pins_out.sda_oe | mdl_oe);
  always #20 clk_in = !clk_in;
  scc_host #(.PWRUP_CYC(PWR), .QTR_CYC(2)) i_scc_host (.scl_in(scl), .sda_in(sda), .*);
  scc_client_model i_scc_client_model (.clk_in(clk_in), .rst_in(rst_in), .addr_in(mdl_addr),
    .scl_in(scl), .sda_in(sda), .sda_oe_out(mdl_oe));
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : rnd
  function automatic scc_proto_t exp_proto(input int s);
    return (s < 3) ? scc_proto_t'(s) : SCC_PROTO_SMBUS;
  endfunction : exp_proto
  function automatic logic [6:0] exp_addr(input int s);
    return (s > 2 && s < 7) ? 7'h2c - 7'(s - 3) : 7'h28;
  endfunction : exp_addr
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Flags are sampled at the falling edge so the driving edge never races them
  task automatic run(input scc_op_t op, input logic [7:0] a, input logic [7:0] n);
    int wi;
    logic tk, wt, dn;
    wi = 0;
    dn = 1'b0;
    rq.delete();
    @(posedge clk_in);
    cmd_in <= '{op: op, reg_addr: a, count: n};
    cmd_valid_in <= 1'b1;
    wr_valid_in <= (wq.size() > 0);
    if (wq.size() > 0) wr_data_in <= wq[0];
    for (int i = 0; i < 5000 && !dn; i++) begin
      @(negedge clk_in);
      tk = cmd_valid_in & cmd_ready_out;
      wt = wr_valid_in & wr_ready_out;
      dn = done_out;
      if (rd_valid_out) rq.push_back(rd_data_out);
      @(posedge clk_in);
      if (tk) cmd_valid_in <= 1'b0;
      wi = wi + int'(wt);
      wr_valid_in <= (wi < wq.size());
      if (wi < wq.size()) wr_data_in <= wq[wi];
    end
    if (!dn) begin
      num_errors++;
      give_verdict();
    end
  endtask : run
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
    wq = '{v};
    run(SCC_OP_WRITE_BYTE, a, 8'h01);
    shadow[a] = v;
  endtask : wr_byte
  task automatic rd_check(input scc_op_t op, input logic [7:0] a, input logic [7:0] exp);
    wq.delete();
    run(op, a, 8'h01);
    if (rq.size() == 0) rq.push_back('x);
    chk8(rq[0], exp);
  endtask : rd_check
  // ****
  // Scenarios
  // ****
  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_in);
      strap_in <= scc_strap_t'(s);
      mdl_addr <= exp_addr(s);
      repeat (PWR + 4) @(posedge clk_in);
      @(negedge clk_in);
      chk8({6'h00, proto_out}, {6'h00, exp_proto(s)});
      if (s > 2) begin
        wr_byte(8'h10 + 8'(s), rnd());
        rd_check(SCC_OP_READ_BYTE, 8'h10 + 8'(s), shadow[8'h10 + 8'(s)]);
      end else chk8({7'h00, cmd_ready_out}, 8'h00);
    end
    $display("strap test done");
    for (int k = 0; k < 6; k++) begin
      ra = rnd();
      d = rnd();
      wr_byte(ra, d);
      chk8({7'h00, nack_out}, 8'h00);
      rd_check(SCC_OP_READ_BYTE, ra, d);
    end
    $display("random byte test done");
    wr_byte(8'h40, 8'ha5);
    wr_byte(8'h41, 8'h5a);
    wq.delete();
    run(SCC_OP_SEND_BYTE, 8'h40, 8'h00);
    chk8(ptr_out, 8'h40);
    rd_check(SCC_OP_RECV_BYTE, 8'h00, 8'ha5);
    rd_check(SCC_OP_RECV_BYTE, 8'h00, 8'ha5);
    $display("pointer test done");
    wq = '{rnd(), rnd(), rnd(), rnd()};
    foreach (wq[j]) shadow[8'hfe + 8'(j)] = wq[j];
    run(SCC_OP_BLOCK_WRITE, 8'hfe, 8'h04);
    chk8(ptr_out, 8'h02);
    wq.delete();
    run(SCC_OP_BLOCK_READ, 8'hfe, 8'h04);
    chk8(8'(rq.size()), 8'h04);
    foreach (rq[j]) chk8(rq[j], shadow[8'hfe + 8'(j)]);
    chk8(ptr_out, 8'h02);
    $display("block test done");
    @(posedge clk_in);
    deep_sleep_flag_in <= 1'b1;
    cmd_in <= '{op: SCC_OP_SEND_BYTE, reg_addr: 8'h00, count: 8'h00};
    @(negedge clk_in);
    chk8({7'h00, cmd_ready_out}, 8'h00);
    rd_check(SCC_OP_READ_BYTE, 8'h40, 8'ha5);
    deep_sleep_flag_in <= 1'b0;
    mdl_addr <= 7'h7f;
    wr_byte(8'h00, 8'h11);
    chk8({7'h00, nack_out}, 8'h01);
    $display("sleep and nack test done");
    give_verdict();
  end
endmodule : scc_host_test
bind scc_host scc_host_sva #(.PWRUP_CYC(PWRUP_CYC), .QTR_CYC(QTR_CYC)) i_scc_host_sva (.*);
